/* File: design/mcsp_regs.svh */
// timing constants for the master clock stop power saver
`ifndef MCSP_REGS_SVH
`define MCSP_REGS_SVH

// ----------------------------------------------------------------------
// reference clock
// ----------------------------------------------------------------------
`define MCSP_REF_PERIOD_NS     10

// ----------------------------------------------------------------------
// master clock limits, in ns
// ----------------------------------------------------------------------
`define MCSP_MCLK_MAX_CYCLE_NS 1000
`define MCSP_SAVE_MIN_NS       2000
`define MCSP_SAVE_MAX_NS       10000

// ----------------------------------------------------------------------
// derived counts in reference cycles (stop and least up, longest saving down)
// ----------------------------------------------------------------------
`define MCSP_STOP_CYC \
  ((`MCSP_MCLK_MAX_CYCLE_NS + `MCSP_REF_PERIOD_NS - 1) / `MCSP_REF_PERIOD_NS)
`define MCSP_SAVE_MIN_CYC \
  ((`MCSP_SAVE_MIN_NS + `MCSP_REF_PERIOD_NS - 1) / `MCSP_REF_PERIOD_NS)
`define MCSP_SAVE_MAX_CYC (`MCSP_SAVE_MAX_NS / `MCSP_REF_PERIOD_NS)

// ----------------------------------------------------------------------
// gap timer width and reset value
// ----------------------------------------------------------------------
`define MCSP_GAP_W             10
`define MCSP_GAP_RST           10'h000

`endif

/* File: design/mcsp_pkg.sv */
// types shared by the master clock stop power saver
`default_nettype none
package mcsp_pkg;

  // operating state of the converter clocking
  typedef enum logic {
    MCSP_RUN,
    MCSP_SAVE
  } mcsp_state_t;

  // status bundle driven to the converter core
  typedef struct packed {
    logic dac_power_down;  // converters powered down
    logic filter_reset;    // interpolation filters held in reset
    logic clock_stopped;   // master clock gap exceeds max cycle time
    logic volume_hold;     // stored volume not yet re-applied
  } mcsp_status_t;

endpackage
`default_nettype wire

/* File: design/mcsp_edge_sync.sv */
// three-stage synchroniser and edge detector for the master clock pin
`default_nettype none
module mcsp_edge_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output var  logic edge_seen
);

  // --------------------------------------------------------------------
  // synchroniser chain
  // --------------------------------------------------------------------
  logic sync1;       // metastability catcher, read only by sync2
  logic sync2;       // settled sample
  logic sync3;       // previous settled sample
  logic level;       // accepted pin level
  logic next_level;  // accepted level after this cycle
  logic next_edge;   // accepted level changes this cycle

  // a change counts only once the second and third stages agree
  always_comb begin
    next_level = level;
    next_edge  = 1'b0;
    if (sync2 == sync3 && sync3 != level) begin
      next_level = sync3;
      next_edge  = 1'b1;
    end
  end

  // register the chain and the edge flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1     <= 1'b0;
      sync2     <= 1'b0;
      sync3     <= 1'b0;
      level     <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      sync1     <= async_in;
      sync2     <= sync1;
      sync3     <= sync2;
      level     <= next_level;
      edge_seen <= next_edge;
    end
  end

endmodule
`default_nettype wire

/* File: design/mcsp_power_saver.sv */
// master clock stop detector and converter power saver
//
// Overview of operation
// - gap beyond max mclk cycle means stopped
// - power saving starts between 2 and 10 us
// - saving powers down converters, resets filters
// - saving keeps registers and control port access
// - returning edges end saving within one cycle
// - volume re-applied only after volume update write
`default_nettype none
`include "mcsp_regs.svh"
module mcsp_power_saver (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          mclk_pin,
  input  wire logic          vol_update_wr,
  output var  mcsp_pkg::mcsp_status_t status,
  output var  logic          ctrl_access_en
);
  import mcsp_pkg::*;

  // --------------------------------------------------------------------
  // constants
  // --------------------------------------------------------------------
  localparam logic [`MCSP_GAP_W-1:0] STOP_CYC     =
    `MCSP_GAP_W'(`MCSP_STOP_CYC);
  localparam logic [`MCSP_GAP_W-1:0] SAVE_MIN_CYC =
    `MCSP_GAP_W'(`MCSP_SAVE_MIN_CYC);
  localparam logic [`MCSP_GAP_W-1:0] SAVE_MAX_CYC =
    `MCSP_GAP_W'(`MCSP_SAVE_MAX_CYC);

  // --------------------------------------------------------------------
  // master clock edge detection
  // --------------------------------------------------------------------
  logic edge_seen;  // one-cycle pulse per synchronised mclk transition

  mcsp_edge_sync u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .async_in  (mclk_pin),
    .edge_seen (edge_seen)
  );

  // --------------------------------------------------------------------
  // gap timer on the reference clock
  // --------------------------------------------------------------------
  logic [`MCSP_GAP_W-1:0] gap_cnt;       // cycles since last mclk edge
  logic [`MCSP_GAP_W-1:0] next_gap_cnt;  // next timer value

  // restart on each edge, otherwise count up and saturate
  always_comb begin
    if (edge_seen) begin
      next_gap_cnt = `MCSP_GAP_RST;
    end else if (gap_cnt >= SAVE_MAX_CYC) begin
      next_gap_cnt = gap_cnt;
    end else begin
      next_gap_cnt = gap_cnt + `MCSP_GAP_W'(1);
    end
  end

  // register the timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_cnt <= `MCSP_GAP_RST;
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end

  // --------------------------------------------------------------------
  // run / save state machine and status outputs
  // --------------------------------------------------------------------
  mcsp_state_t  state;       // current operating state
  mcsp_state_t  next_state;  // next operating state
  mcsp_status_t next_status; // next status bundle
  logic         resume;      // first mclk edge seen while saving

  // state transitions and status derivation
  always_comb begin
    next_state = state;
    resume     = 1'b0;
    case (state)
      MCSP_RUN: begin
        // enter saving once the gap reaches the minimum
        if (!edge_seen && next_gap_cnt >= SAVE_MIN_CYC) begin
          next_state = MCSP_SAVE;
        end
      end
      MCSP_SAVE: begin
        // any edge brings the converters back
        if (edge_seen) begin
          next_state = MCSP_RUN;
          resume     = 1'b1;
        end
      end
      default: begin
        next_state = MCSP_RUN;
      end
    endcase
    // converters down and filters reset while saving
    next_status.dac_power_down = (next_state == MCSP_SAVE);
    next_status.filter_reset   = (next_state == MCSP_SAVE);
    // gap longer than the max cycle time counts as stopped
    next_status.clock_stopped  = (next_gap_cnt >= STOP_CYC);
    // hold volume after resume until software update; set wins
    if (resume) begin
      next_status.volume_hold = 1'b1;
    end else if (vol_update_wr) begin
      next_status.volume_hold = 1'b0;
    end else begin
      next_status.volume_hold = status.volume_hold;
    end
  end

  // register state and status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state          <= MCSP_RUN;
      status         <= '0;
      ctrl_access_en <= 1'b0;
    end else begin
      state          <= next_state;
      status         <= next_status;
      // control port stays open in every state
      ctrl_access_en <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------
  a_stop_before_save:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(status.clock_stopped) |-> !status.dac_power_down)
    else $error("stopped flag did not precede power saving");

  a_stop_flag_set:
    assert property (@(posedge ref_clk) disable iff (rst)
      (!edge_seen && gap_cnt == STOP_CYC - 1) |=> status.clock_stopped)
    else $error("clock stop not flagged after max cycle time");

  a_save_not_early:
    assert property (@(posedge ref_clk) disable iff (rst)
      $rose(status.dac_power_down) |-> gap_cnt == SAVE_MIN_CYC)
    else $error("power saving entered at wrong gap length");

  a_save_not_late:
    assert property (@(posedge ref_clk) disable iff (rst)
      (gap_cnt == SAVE_MAX_CYC) |-> status.dac_power_down)
    else $error("power saving not entered within maximum time");

  a_filter_reset:
    assert property (@(posedge ref_clk) disable iff (rst)
      status.dac_power_down |-> status.filter_reset throughout
        (status.dac_power_down [*1]))
    else $error("filters not reset while converters down");

  a_ctrl_access:
    assert property (@(posedge ref_clk) disable iff (rst)
      status.dac_power_down |-> ctrl_access_en)
    else $error("control port closed during power saving");

  a_resume_fast:
    assert property (@(posedge ref_clk) disable iff (rst)
      (status.dac_power_down && edge_seen) |=>
        (!status.dac_power_down && !status.filter_reset))
    else $error("normal mode not resumed after mclk edge");

  a_vol_hold_set:
    assert property (@(posedge ref_clk) disable iff (rst)
      (status.dac_power_down && edge_seen) |=> status.volume_hold)
    else $error("volume hold not raised on resume");

  a_vol_hold_keep:
    assert property (@(posedge ref_clk) disable iff (rst)
      (status.volume_hold && !vol_update_wr) |=> status.volume_hold)
    else $error("volume hold dropped without update write");

  a_timer_runs:
    assert property (@(posedge ref_clk) disable iff (rst)
      (!edge_seen && gap_cnt < SAVE_MAX_CYC) |=>
        gap_cnt == $past(gap_cnt) + `MCSP_GAP_W'(1))
    else $error("gap timer stalled without mclk edges");

endmodule
`default_nettype wire

/* File: dv/mcsp_mclk_src.sv */
// master clock source model for the power saver bench
`default_nettype none
module mcsp_mclk_src (
  input  wire logic        run,      // toggles while high
  input  wire logic [15:0] half_ns,  // half period in ns
  output var  logic        mclk      // modelled master clock pin
);
  timeunit 1ns;
  timeprecision 1ps;

  int   cnt = 0;     // ns since last toggle
  logic lvl = 1'b0;  // clock level, starts low

  assign mclk = lvl;

  // ----------------------------------------------------------------------
  // free running 1 ns tick, unrelated to the reference clock
  // ----------------------------------------------------------------------
  always #1 begin
    if (run !== 1'b1) begin
      cnt = 0;  // stopped: level stands still
    end else if (cnt + 1 >= int'(half_ns)) begin
      cnt = 0;
      lvl = ~lvl;  // bench keeps the period within 1000 ns
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: dv/test_mclk_stop_power_saver.sv */
// self-checking bench for the master clock stop power saver
`default_nettype none
module test_mclk_stop_power_saver;
  timeunit 1ns;
  timeprecision 1ps;
  import mcsp_pkg::*;

  logic         ref_clk;          // 100 MHz reference
  logic         rst;              // async reset
  logic         vol_update_wr;    // volume update write pulse
  logic         ctrl_access_en;   // control port enable
  logic         mclk_pin;         // master clock from the model
  logic         run;              // model running
  logic [15:0]  half_ns;          // model half period
  mcsp_status_t status;           // converter status bundle
  int           errors;           // mismatches
  int           samples_checked;  // comparisons

  mcsp_power_saver DUT (.ref_clk(ref_clk), .rst(rst), .mclk_pin(mclk_pin),
    .vol_update_wr(vol_update_wr), .status(status),
    .ctrl_access_en(ctrl_access_en));
  mcsp_mclk_src src (.run(run), .half_ns(half_ns), .mclk(mclk_pin));

  // ----------------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic rng(input string what, input int lo, input int hi,
                     input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // bounded wait for the next master clock transition
  task automatic wait_mclk();
    logic last;
    int   n;
    last = mclk_pin;
    n = 0;
    while (mclk_pin === last && n < 200) begin
      @(mclk_pin or posedge ref_clk);
      n++;
    end
    if (mclk_pin === last) begin
      errors++;
      $display("Error mclk_pin expected toggle seen %0b", last);
      stop_test();
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // slowest legal clock never looks stopped
  task automatic t_run();
    half_ns = 16'h01EF;
    run = 1'b1;
    repeat (600) begin
      @(negedge ref_clk);
      chk("status", 4'h0, status);
    end
    $display("t_run done");
  endtask

  // stop right after an edge, measure flag and saving delays
  task automatic t_stop();
    int n;
    int n_stop;
    wait_mclk();
    run = 1'b0;
    n = 0;
    n_stop = 0;
    while (status.dac_power_down !== 1'b1 && n < 1100) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (status.clock_stopped === 1'b1 && n_stop == 0) begin
        n_stop = n;
      end
    end
    rng("stop flag cycles", 100, 200, n_stop);
    rng("saving cycles", 200, 1000, n);
    if (n >= 1100) begin
      stop_test();
    end
    repeat (300) begin
      @(negedge ref_clk);
      chk("status", 4'hE, status);
      chk("ctrl_access_en", 1'b1, ctrl_access_en);
    end
    $display("t_stop done");
  endtask

  // restart the clock, saving must end within one mclk cycle
  task automatic t_resume();
    int n;
    half_ns = 16'h0032;
    run = 1'b1;
    wait_mclk();
    n = 0;
    while (status.dac_power_down !== 1'b0 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    rng("resume cycles", 1, 10, n);
    if (n >= 20) begin
      stop_test();
    end
    chk("status", 4'h1, status);
    $display("t_resume done");
  endtask

  // volume held until the update write arrives
  task automatic t_volume();
    repeat (50) begin
      @(negedge ref_clk);
      chk("volume_hold", 1'b1, status.volume_hold);
    end
    vol_update_wr = 1'b1;
    @(negedge ref_clk);
    vol_update_wr = 1'b0;
    @(negedge ref_clk);
    chk("status", 4'h0, status);
    $display("t_volume done");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    vol_update_wr = 1'b0;
    run = 1'b0;
    half_ns = 16'h0032;
    errors = 0;
    samples_checked = 0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    chk("ctrl_access_en", 1'b1, ctrl_access_en);
    t_run();
    t_stop();
    t_resume();
    t_volume();
    t_stop();
    t_resume();
    stop_test();
  end
endmodule
`default_nettype wire
